// ==== rtl/tlbc_map.svh ====
// Register indices, field positions and reset values of the translation block
`ifndef TLBC_MAP_SVH
`define TLBC_MAP_SVH
// Register indices; byte address is four times the index
`define TLBC_IDX_PAGE_MASK 6'h05
`define TLBC_IDX_BOUNDARY 6'h06
`define TLBC_IDX_FAULT_VA 6'h08
`define TLBC_IDX_ENTRY_HI 6'h0a
`define TLBC_IDX_RANDOM 6'h10
`define TLBC_IDX_CONFIG 6'h11
`define TLBC_IDX_MODE 6'h12
// Field positions
`define TLBC_MASK_LSB 13
`define TLBC_MASK_MSB 24
`define TLBC_PAGE_PAIR_NUMBER_LSB 13
`define TLBC_CFG_ONCHIP_BIT 3
`define TLBC_MODE_UM_BIT 0
`define TLBC_MODE_EXL_BIT 1
`define TLBC_MODE_ERL_BIT 2
// Reset values and bounds
`define TLBC_RAND_TOP 4'hf
`define TLBC_BOUNDARY_RST 6'h00
`define TLBC_CONFIG_RST 4'h0
`define TLBC_MODE_RST 3'h4
`define TLBC_NUM_ENTRIES 16
// Unmapped segment bases
`define TLBC_SEG0_BASE 32'h8000_0000
`define TLBC_SEG1_BASE 32'ha000_0000
`endif

// ==== rtl/tlbc_pkg.sv ====
// Types shared by the translation control block
package tlbc_pkg;
  // Address segment chosen by the decoder
  typedef enum logic [2:0] {
    SEG_USER = 3'b000,
    SEG_UNMAPPED_CACHED = 3'b001,
    SEG_UNMAPPED_UNCACHED = 3'b010,
    SEG_MAPPED_KERNEL = 3'b011,
    SEG_ONCHIP = 3'b100,
    SEG_ADDR_ERR = 3'b101
  } tlbc_seg_type;
  // Exception kinds reported by the pipeline
  typedef enum logic [2:0] {
    EXC_ADDR_ERR = 3'b000,
    EXC_TLB_INVALID = 3'b001,
    EXC_TLB_MODIFIED = 3'b010,
    EXC_TLB_REFILL = 3'b011,
    EXC_VC_DATA = 3'b100,
    EXC_VC_INSTR = 3'b101,
    EXC_BUS_ERR = 3'b110,
    EXC_OTHER = 3'b111
  } tlbc_exc_type;
  // One translation buffer entry, high half only
  typedef struct packed {
    logic valid;
    logic global_both;
    logic [18:0] page_pair_number;
    logic [7:0] process_space_tag;
    logic [11:0] page_size_mask;
  } tlbc_entry_type;
  // Registered answer to a translation request
  typedef struct packed {
    logic valid;
    tlbc_seg_type seg;
    logic mapped;
    logic hit;
    logic [3:0] hit_index;
    logic [31:0] phys_addr;
    logic uncached;
    logic [2:0] cache_attr;
  } tlbc_xlate_type;
endpackage

// ==== rtl/tlbc_top.sv ====
// Translation control: mask, boundary, fault capture, modes, segments
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "tlbc_map.svh"
module tlbc_top (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_instr_valid,
  input wire logic i_exc_valid,
  input wire tlbc_pkg::tlbc_exc_type i_exc_code,
  input wire logic [31:0] i_exc_vaddr,
  input wire logic i_exception_return_op,
  input wire logic i_tlb_wr_indexed,
  input wire logic i_tlb_wr_random,
  input wire logic [3:0] i_tlb_index,
  input wire logic i_tlb_global_both,
  input wire logic i_xlate_req,
  input wire logic [31:0] i_xlate_va,
  output tlbc_pkg::tlbc_xlate_type o_xlate,
  output logic o_kernel_mode
);

  // Software visible state
  logic [11:0] page_size_mask_r; // Mask bits 24:13 only
  logic [5:0] boundary_r; // Locked entry count
  logic [3:0] random_r; // Replacement pointer
  logic [31:0] fault_va_r; // Faulting virtual address
  logic [18:0] ehi_pair_r; // Entry high page pair number
  logic [7:0] ehi_tag_r; // Entry high space tag
  logic [3:0] config_r; // Attr in 2:0, on-chip disable in 3
  logic user_mode_bit_r;
  logic exception_level_bit_r;
  logic error_level_bit_r;
  logic user_mode_bit_nxt;
  logic exception_level_bit_nxt;
  logic error_level_bit_nxt;
  // Bus handshake state
  logic [31:0] prdata_nxt;
  logic slverr_nxt;
  // Entry array
  tlbc_pkg::tlbc_entry_type entry_r [`TLBC_NUM_ENTRIES];
  logic [`TLBC_NUM_ENTRIES-1:0] match_vec;
  tlbc_pkg::tlbc_xlate_type xlate_nxt;

  // Decoded bus strobes
  logic setup_cyc;
  logic wr_go;
  logic [5:0] reg_idx;
  logic mapped_reg;
  logic wr_mask;
  logic wr_bound;
  logic wr_ehi;
  logic wr_cfg;
  logic wr_mode;
  logic exc_addressing;
  logic exc_xlate;
  logic user_now;

  assign setup_cyc = i_psel & ~i_penable;
  assign wr_go = i_psel & i_penable & i_pwrite & o_pready;
  assign reg_idx = i_paddr[7:2];
  assign wr_mask = wr_go & (reg_idx == `TLBC_IDX_PAGE_MASK);
  assign wr_bound = wr_go & (reg_idx == `TLBC_IDX_BOUNDARY);
  assign wr_ehi = wr_go & (reg_idx == `TLBC_IDX_ENTRY_HI);
  assign wr_cfg = wr_go & (reg_idx == `TLBC_IDX_CONFIG);
  assign wr_mode = wr_go & (reg_idx == `TLBC_IDX_MODE);

  // Exceptions that record an address
  assign exc_addressing = i_exc_valid &
    (i_exc_code != tlbc_pkg::EXC_BUS_ERR) &
    (i_exc_code != tlbc_pkg::EXC_OTHER);
  // Exceptions that reload entry high
  assign exc_xlate = i_exc_valid &
    ((i_exc_code == tlbc_pkg::EXC_TLB_REFILL) |
     (i_exc_code == tlbc_pkg::EXC_TLB_INVALID) |
     (i_exc_code == tlbc_pkg::EXC_TLB_MODIFIED));

  // Read mux, unmapped indices flagged
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    mapped_reg = 1'b1;
    unique case (reg_idx)
      `TLBC_IDX_PAGE_MASK:
        prdata_nxt[`TLBC_MASK_MSB:`TLBC_MASK_LSB] = page_size_mask_r;
      `TLBC_IDX_BOUNDARY: prdata_nxt[5:0] = boundary_r;
      `TLBC_IDX_FAULT_VA: prdata_nxt = fault_va_r;
      `TLBC_IDX_ENTRY_HI: prdata_nxt = {ehi_pair_r, 5'h00, ehi_tag_r};
      `TLBC_IDX_RANDOM: prdata_nxt[3:0] = random_r;
      `TLBC_IDX_CONFIG: prdata_nxt[3:0] = config_r;
      `TLBC_IDX_MODE: prdata_nxt[2:0] = {error_level_bit_r,
        exception_level_bit_r, user_mode_bit_r};
      default: mapped_reg = 1'b0;
    endcase
    slverr_nxt = ~mapped_reg;
  end

  // Bus answer: ready in the first access cycle
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup_cyc) begin
      o_pready <= 1'b1;
      o_prdata <= prdata_nxt;
      o_pslverr <= slverr_nxt;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // Page mask register, only the mask field is kept
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_size_mask_r <= 12'h000;
    end else if (wr_mask) begin
      page_size_mask_r <= i_pwdata[`TLBC_MASK_MSB:`TLBC_MASK_LSB];
    end
  end

  // Locked entry boundary and configuration
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boundary_r <= `TLBC_BOUNDARY_RST;
      config_r <= `TLBC_CONFIG_RST;
    end else begin
      if (wr_bound) begin
        boundary_r <= i_pwdata[5:0];
      end
      if (wr_cfg) begin
        config_r <= i_pwdata[3:0];
      end
    end
  end

  // Replacement pointer walks down to the boundary
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      random_r <= `TLBC_RAND_TOP;
    end else if (wr_bound) begin
      random_r <= `TLBC_RAND_TOP;
    end else if (i_instr_valid) begin
      if ({2'b00, random_r} <= boundary_r) begin
        random_r <= `TLBC_RAND_TOP;
      end else begin
        random_r <= random_r - 4'h1;
      end
    end
  end

  // Fault address capture, frozen at exception level
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_va_r <= 32'h0000_0000;
    end else if (exc_addressing && !exception_level_bit_r) begin
      fault_va_r <= i_exc_vaddr;
    end
  end

  // Entry high: hardware load wins over software write
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ehi_pair_r <= 19'h00000;
      ehi_tag_r <= 8'h00;
    end else if (exc_xlate) begin
      ehi_pair_r <= i_exc_vaddr[31:`TLBC_PAGE_PAIR_NUMBER_LSB];
    end else if (wr_ehi) begin
      ehi_pair_r <= i_pwdata[31:`TLBC_PAGE_PAIR_NUMBER_LSB];
      ehi_tag_r <= i_pwdata[7:0];
    end
  end

  // Mode bits: exception set wins over return and writes
  always_comb begin
    user_mode_bit_nxt = user_mode_bit_r;
    exception_level_bit_nxt = exception_level_bit_r;
    error_level_bit_nxt = error_level_bit_r;
    if (wr_mode) begin
      user_mode_bit_nxt = i_pwdata[`TLBC_MODE_UM_BIT];
      exception_level_bit_nxt = i_pwdata[`TLBC_MODE_EXL_BIT];
      error_level_bit_nxt = i_pwdata[`TLBC_MODE_ERL_BIT];
    end
    if (i_exception_return_op) begin
      // Return drops the error level first
      if (error_level_bit_r) begin
        error_level_bit_nxt = 1'b0;
      end else begin
        exception_level_bit_nxt = 1'b0;
      end
    end
    if (i_exc_valid) begin
      exception_level_bit_nxt = 1'b1;
    end
  end

  // Mode registers and the registered kernel flag
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      user_mode_bit_r <= 1'b0;
      exception_level_bit_r <= 1'b0;
      error_level_bit_r <= 1'b1;
      o_kernel_mode <= 1'b1;
    end else begin
      user_mode_bit_r <= user_mode_bit_nxt;
      exception_level_bit_r <= exception_level_bit_nxt;
      error_level_bit_r <= error_level_bit_nxt;
      o_kernel_mode <= ~(user_mode_bit_nxt & ~exception_level_bit_nxt &
        ~error_level_bit_nxt);
    end
  end

  // Entry writes: random slot or any indexed slot
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < `TLBC_NUM_ENTRIES; i++) begin
        entry_r[i] <= '0;
      end
    end else if (i_tlb_wr_indexed || i_tlb_wr_random) begin
      // Indexed slot bypasses the boundary
      entry_r[i_tlb_wr_indexed ? i_tlb_index : random_r] <= '{
        valid: 1'b1,
        global_both: i_tlb_global_both,
        page_pair_number: ehi_pair_r,
        process_space_tag: ehi_tag_r,
        page_size_mask: page_size_mask_r};
    end
  end

  // Per entry tag compare under its mask
  generate
    for (genvar g = 0; g < `TLBC_NUM_ENTRIES; g++) begin : g_cmp
      logic [18:0] keep;
      assign keep = ~{7'h00, entry_r[g].page_size_mask};
      assign match_vec[g] = entry_r[g].valid &
        (((entry_r[g].page_pair_number ^
           i_xlate_va[31:`TLBC_PAGE_PAIR_NUMBER_LSB]) & keep) == 19'h00000) &
        (entry_r[g].global_both |
         (entry_r[g].process_space_tag == ehi_tag_r));
    end
  endgenerate

  assign user_now = user_mode_bit_r & ~exception_level_bit_r &
    ~error_level_bit_r;

  // Segment decode and lookup result
  always_comb begin
    xlate_nxt = '0;
    xlate_nxt.valid = i_xlate_req;
    xlate_nxt.cache_attr = config_r[2:0];
    for (int i = `TLBC_NUM_ENTRIES - 1; i >= 0; i--) begin
      if (match_vec[i]) begin
        xlate_nxt.hit = 1'b1;
        xlate_nxt.hit_index = 4'(i);
      end
    end
    if (!i_xlate_va[31]) begin
      xlate_nxt.seg = tlbc_pkg::SEG_USER;
      xlate_nxt.mapped = 1'b1;
    end else if (user_now) begin
      xlate_nxt.seg = tlbc_pkg::SEG_ADDR_ERR;
    end else if (i_xlate_va[31:29] == 3'b100) begin
      xlate_nxt.seg = tlbc_pkg::SEG_UNMAPPED_CACHED;
      xlate_nxt.phys_addr = i_xlate_va - `TLBC_SEG0_BASE;
    end else if (i_xlate_va[31:29] == 3'b101) begin
      xlate_nxt.seg = tlbc_pkg::SEG_UNMAPPED_UNCACHED;
      xlate_nxt.phys_addr = i_xlate_va - `TLBC_SEG1_BASE;
      xlate_nxt.uncached = 1'b1;
    end else if ((i_xlate_va[31:24] != 8'hff) ||
                 config_r[`TLBC_CFG_ONCHIP_BIT]) begin
      xlate_nxt.seg = tlbc_pkg::SEG_MAPPED_KERNEL;
      xlate_nxt.mapped = 1'b1;
    end else begin
      xlate_nxt.seg = tlbc_pkg::SEG_ONCHIP;
      xlate_nxt.phys_addr = i_xlate_va;
      xlate_nxt.uncached = 1'b1;
    end
    if (!xlate_nxt.mapped) begin
      xlate_nxt.hit = 1'b0;
      xlate_nxt.hit_index = 4'h0;
    end
  end

  // Registered translation answer
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_xlate <= '0;
    end else begin
      o_xlate <= xlate_nxt;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // Boundary write followed by pointer at the top
  sequence s_bound_wr;
    wr_bound;
  endsequence
  property p_bound_top;
    s_bound_wr |=> (random_r == `TLBC_RAND_TOP) &&
      (boundary_r == $past(i_pwdata[5:0]));
  endproperty
  a_bound_top: assert property (p_bound_top)
    else $error("pointer not at top after boundary write");

  property p_rand_step;
    (i_instr_valid && !wr_bound && ({2'b00, random_r} > boundary_r)) |=>
      (random_r == $past(random_r) - 4'h1);
  endproperty
  a_rand_step: assert property (p_rand_step)
    else $error("pointer did not step down");

  property p_rand_floor;
    (boundary_r <= 6'h0f) |-> ({2'b00, random_r} >= boundary_r);
  endproperty
  a_rand_floor: assert property (p_rand_floor)
    else $error("pointer below locked boundary");

  property p_fault_frozen;
    exception_level_bit_r |=> $stable(fault_va_r);
  endproperty
  a_fault_frozen: assert property (p_fault_frozen)
    else $error("fault address changed at exception level");

  property p_fault_bus;
    (i_exc_valid && i_exc_code == tlbc_pkg::EXC_BUS_ERR) |=>
      $stable(fault_va_r);
  endproperty
  a_fault_bus: assert property (p_fault_bus)
    else $error("bus error changed fault address");

  property p_fault_load;
    (i_exc_valid && i_exc_code == tlbc_pkg::EXC_TLB_REFILL &&
     !exception_level_bit_r) |=>
      (fault_va_r == $past(i_exc_vaddr)) &&
      (ehi_pair_r == $past(i_exc_vaddr[31:13]));
  endproperty
  a_fault_load: assert property (p_fault_load)
    else $error("refill did not record address");

  // Exception then stays kernel until return
  sequence s_exc;
    i_exc_valid ##1 !i_exception_return_op && !wr_mode;
  endsequence
  property p_kernel_hold;
    s_exc |=> o_kernel_mode;
  endproperty
  a_kernel_hold: assert property (p_kernel_hold)
    else $error("left kernel mode without return");

  property p_seg1;
    (i_xlate_req && i_xlate_va[31:29] == 3'b101 && !user_now) |=>
      (o_xlate.seg == tlbc_pkg::SEG_UNMAPPED_UNCACHED) && o_xlate.uncached &&
      (o_xlate.phys_addr == ($past(i_xlate_va) - 32'ha000_0000));
  endproperty
  a_seg1: assert property (p_seg1)
    else $error("uncached segment decoded wrongly");

  property p_user_err;
    (i_xlate_req && i_xlate_va[31] && user_now) |=>
      (o_xlate.seg == tlbc_pkg::SEG_ADDR_ERR);
  endproperty
  a_user_err: assert property (p_user_err)
    else $error("user access to kernel space not refused");

  property p_onchip;
    (i_xlate_req && i_xlate_va[31:24] == 8'hff && !user_now) |=>
      (o_xlate.seg == ($past(config_r[3]) ? tlbc_pkg::SEG_MAPPED_KERNEL :
                       tlbc_pkg::SEG_ONCHIP));
  endproperty
  a_onchip: assert property (p_onchip)
    else $error("top region decoded wrongly");

endmodule

// ==== verif/tlbc_pipe_model.sv ====
// Pipeline model: retires, traps, returns, writes entries, asks lookups
`timescale 1ns/1ps
module tlbc_pipe_model (
  input wire logic i_mclk,
  input wire tlbc_pkg::tlbc_xlate_type i_xlate,
  output logic o_instr_valid,
  output logic o_exc_valid,
  output tlbc_pkg::tlbc_exc_type o_exc_code,
  output logic [31:0] o_exc_vaddr,
  output logic o_ret,
  output logic o_wr_indexed,
  output logic o_wr_random,
  output logic [3:0] o_index,
  output logic o_global,
  output logic o_req,
  output logic [31:0] o_va
);
  // Idle levels at time zero
  initial begin
    o_instr_valid = 1'b0;
    o_exc_valid = 1'b0;
    o_exc_code = tlbc_pkg::EXC_OTHER;
    o_exc_vaddr = 32'h0;
    o_ret = 1'b0;
    o_wr_indexed = 1'b0;
    o_wr_random = 1'b0;
    o_index = 4'h0;
    o_global = 1'b0;
    o_req = 1'b0;
    o_va = 32'h0;
  end
  // Retire n instructions back to back
  task automatic retire(input int n);
    @(posedge i_mclk);
    o_instr_valid <= 1'b1;
    repeat (n) @(posedge i_mclk);
    o_instr_valid <= 1'b0;
  endtask
  // Take one exception; address is scrambled once dropped
  task automatic exc(input tlbc_pkg::tlbc_exc_type c, input logic [31:0] a);
    @(posedge i_mclk);
    o_exc_valid <= 1'b1;
    o_exc_code <= c;
    o_exc_vaddr <= a;
    @(posedge i_mclk);
    o_exc_valid <= 1'b0;
    o_exc_vaddr <= ~a;
    @(posedge i_mclk);
    #1;
  endtask
  // Return from exception
  task automatic ret();
    @(posedge i_mclk);
    o_ret <= 1'b1;
    @(posedge i_mclk);
    o_ret <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask
  // Entry write, indexed or at the random pointer
  task automatic tlbw(input logic rnd, input logic [3:0] i, input logic g);
    @(posedge i_mclk);
    o_wr_indexed <= !rnd;
    o_wr_random <= rnd;
    o_index <= i;
    o_global <= g;
    @(posedge i_mclk);
    o_wr_indexed <= 1'b0;
    o_wr_random <= 1'b0;
    o_index <= ~i;
  endtask
  // One lookup; answer sampled one cycle after the request
  task automatic xlate(input logic [31:0] a,
                       output tlbc_pkg::tlbc_xlate_type r);
    @(posedge i_mclk);
    o_req <= 1'b1;
    o_va <= a;
    @(posedge i_mclk);
    o_req <= 1'b0;
    o_va <= ~a;
    #1;
    r = i_xlate;
  endtask
endmodule

// ==== verif/tb_tlbc_top.sv ====
// Self-checking bench for the translation control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_tlbc_top;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic iv, ev, ret, wi, wr, gb, req, km, mp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, va, va1, va2, fva, eh, eva, xva;
  logic [3:0] idx;
  tlbc_pkg::tlbc_exc_type ec;
  tlbc_pkg::tlbc_xlate_type xl, res;
  tlbc_pkg::tlbc_seg_type sg;
  integer seed = 32'h31dced98;
  int errors = 0;
  int num_checks = 0;
  tlbc_top u_tlbc_top (.i_mclk(mclk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_instr_valid(iv), .i_exc_valid(ev),
    .i_exc_code(ec), .i_exc_vaddr(eva), .i_exception_return_op(ret),
    .i_tlb_wr_indexed(wi), .i_tlb_wr_random(wr), .i_tlb_index(idx),
    .i_tlb_global_both(gb), .i_xlate_req(req), .i_xlate_va(xva),
    .o_xlate(xl), .o_kernel_mode(km));
  tlbc_pipe_model u_tlbc_pipe_model (.i_mclk(mclk), .i_xlate(xl),
    .o_instr_valid(iv), .o_exc_valid(ev), .o_exc_code(ec),
    .o_exc_vaddr(eva), .o_ret(ret), .o_wr_indexed(wi), .o_wr_random(wr),
    .o_index(idx), .o_global(gb), .o_req(req), .o_va(xva));
  // Clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    if (n >= 20) errors++;
    // Return once the answering edge has settled
    #1;
  endtask
  // Read and compare one register
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // Lookup and compare hit and index
  task automatic look(input logic [31:0] a, input logic h,
                      input logic [3:0] i);
    u_tlbc_pipe_model.xlate(a, res);
    `CHK("hit", h, res.hit)
    if (h) `CHK("hit_index", i, res.hit_index)
  endtask
  // Random pointer after n steps from the top
  function automatic logic [31:0] rexp(input int b, input int n);
    int r;
    r = 15;
    repeat (n) r = (r <= b) ? 15 : r - 1;
    return r;
  endfunction
  // Segment expected for an address in the given mode and config
  function automatic tlbc_pkg::tlbc_seg_type seg_of(input logic [31:0] a,
                                                    input logic u, oc);
    if (!a[31]) return tlbc_pkg::SEG_USER;
    if (u) return tlbc_pkg::SEG_ADDR_ERR;
    if (a[31:29] == 3'b100) return tlbc_pkg::SEG_UNMAPPED_CACHED;
    if (a[31:29] == 3'b101) return tlbc_pkg::SEG_UNMAPPED_UNCACHED;
    if (a[31:24] == 8'hff && !oc) return tlbc_pkg::SEG_ONCHIP;
    return tlbc_pkg::SEG_MAPPED_KERNEL;
  endfunction
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [7:0] tops [8];
    logic [2:0] at;
    tops = '{8'h12, 8'h80, 8'h9f, 8'ha0, 8'hbf, 8'hc0, 8'hfe, 8'hff};
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk("boundary", 8'h18, 32'h0);
    rdchk("random", 8'h40, 32'hf);
    `CHK("kmode", 1'b1, km)
    for (int k = 0; k < 7; k++) begin
      va = ((32'h1 << (2 * k)) - 32'h1) << 13;
      apb(1'b1, 8'h14, va);
      rdchk("mask", 8'h14, va);
    end
    $display("mask test done");
    apb(1'b1, 8'h48, 32'h0);
    for (int oc = 0; oc < 2; oc++) begin
      at = 3'($random(seed) & 3);
      apb(1'b1, 8'h44, {28'h0, oc[0], at});
      foreach (tops[t]) begin
        va = {tops[t], 24'($random(seed))};
        u_tlbc_pipe_model.xlate(va, res);
        sg = seg_of(va, 1'b0, oc[0]);
        mp = (sg == tlbc_pkg::SEG_USER) || (sg == tlbc_pkg::SEG_MAPPED_KERNEL);
        `CHK("valid", 1'b1, res.valid)
        `CHK("seg", sg, res.seg)
        `CHK("mapped", mp, res.mapped)
        `CHK("attr", at, res.cache_attr)
        if (sg == tlbc_pkg::SEG_UNMAPPED_CACHED)
          `CHK("pa0", va - 32'h8000_0000, res.phys_addr)
        if (sg == tlbc_pkg::SEG_UNMAPPED_UNCACHED) begin
          `CHK("pa1", va - 32'ha000_0000, res.phys_addr)
          `CHK("unc", 1'b1, res.uncached)
        end
      end
    end
    $display("segment test done");
    // Move the pointer off the top so the boundary write shows
    u_tlbc_pipe_model.retire(3);
    rdchk("random", 8'h40, rexp(0, 3));
    apb(1'b1, 8'h18, 32'h5);
    rdchk("random", 8'h40, 32'hf);
    u_tlbc_pipe_model.retire(13);
    rdchk("random", 8'h40, rexp(5, 13));
    apb(1'b1, 8'h18, 32'h5);
    va1 = {1'b0, 31'($random(seed))};
    va2 = va1 ^ 32'h0100_0000;
    apb(1'b1, 8'h14, 32'h6000);
    apb(1'b1, 8'h28, {va1[31:13], 13'h2a});
    u_tlbc_pipe_model.tlbw(1'b0, 4'h2, 1'b0);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h28, {va2[31:13], 13'h2a});
    u_tlbc_pipe_model.tlbw(1'b1, 4'h0, 1'b0);
    look(va1 ^ 32'h6000, 1'b1, 4'h2);
    look(va1 ^ 32'h8000, 1'b0, 4'h0);
    look(va2, 1'b1, 4'hf);
    apb(1'b1, 8'h28, {va2[31:13], 13'h55});
    look(va2, 1'b0, 4'h0);
    u_tlbc_pipe_model.tlbw(1'b0, 4'h7, 1'b1);
    eh = {va2[31:13], 13'h66};
    apb(1'b1, 8'h28, eh);
    look(va2, 1'b1, 4'h7);
    $display("lookup test done");
    apb(1'b1, 8'h48, 32'h1);
    fva = 32'h0;
    for (int c = 0; c < 8; c++) begin
      `CHK("umode", 1'b0, km)
      va = $random(seed);
      u_tlbc_pipe_model.exc(tlbc_pkg::tlbc_exc_type'(c), va);
      `CHK("kmode", 1'b1, km)
      if (c < 6) fva = va;
      if (c >= 1 && c <= 3) eh = {va[31:13], eh[12:0]};
      u_tlbc_pipe_model.exc(tlbc_pkg::EXC_ADDR_ERR, ~va);
      apb(1'b1, 8'h20, ~va);
      rdchk("fault", 8'h20, fva);
      rdchk("entry_hi", 8'h28, eh);
      u_tlbc_pipe_model.ret();
    end
    u_tlbc_pipe_model.xlate(32'h8000_0000, res);
    `CHK("useg", tlbc_pkg::SEG_ADDR_ERR, res.seg)
    $display("exception test done");
    apb(1'b0, 8'h3c, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("rd_unmapped", 32'h0, rd)
    $display("unmapped test done");
    end_of_test();
  end
endmodule
